//--- hdl/perf_counter_pkg.sv
package perf_counter_pkg;

   // -----------------------------------------------------------------
   // Register offsets (byte addresses within the special register space)
   // -----------------------------------------------------------------
   localparam logic [15:0] counter_control_offset             = 16'hfc00;
   localparam logic [15:0] clock_cycle_counter_offset         = 16'hfc04;
   localparam logic [15:0] retired_instruction_counter_offset = 16'hfc08;
   localparam logic [15:0] event_counter_one_offset           = 16'hfc0c;
   localparam logic [15:0] event_counter_two_offset           = 16'hfc10;
   localparam logic [15:0] event_counter_three_offset         = 16'hfc14;

   // -----------------------------------------------------------------
   // Control register fields
   // -----------------------------------------------------------------
   localparam int          mode_bit_pos          = 0;
   localparam int          enable_bit_pos        = 1;
   localparam int          select_one_lsb        = 2;
   localparam int          select_two_lsb        = 5;
   localparam int          select_three_lsb      = 8;
   localparam int          select_width          = 3;
   localparam int          control_width         = 11;
   localparam logic [10:0] control_reset_value   = 11'h000;

   // -----------------------------------------------------------------
   // Counter layout
   // -----------------------------------------------------------------
   localparam int          count_width           = 31;
   localparam int          sticky_bit_pos        = 31;
   localparam int          counter_total         = 5;
   localparam logic [31:0] counter_reset_value   = 32'h0000_0000;

   // Event selector count: number of implemented sources per selector.
   localparam int          event_source_count    = 8;

endpackage

//--- hdl/event_select_mux.sv
`timescale 1ns/1ps

// Picks one implementation-specific event pulse out of a source vector.
module event_select_mux #(
   parameter int SOURCES = 8
) (
   input  wire logic [SOURCES-1:0] events_i,
   input  wire logic [2:0]         select_i,
   output logic                    event_o
);

   // A three-bit selector cannot reach more than eight sources.
   if (SOURCES < 1 || SOURCES > 8) begin : g_bad_sources
      $error("event_select_mux: SOURCES must be 1..8");
   end

   // -----------------------------------------------------------------
   // Selection
   // -----------------------------------------------------------------

   // Unimplemented codes select nothing so that they never count.
   always_comb begin
      event_o = 1'b0;
      if (32'(select_i) < SOURCES) begin
         event_o = events_i[select_i];
      end
   end

endmodule

//--- hdl/wrap_counter.sv
`timescale 1ns/1ps

// One 31-bit wrapping counter with a sticky wrap flag in bit 31.
module wrap_counter #(
   parameter int WIDTH = 31
) (
   input  wire logic             sys_clk_i,
   input  wire logic             reset_i,
   input  wire logic             count_i,
   input  wire logic             write_i,
   input  wire logic [WIDTH:0]   write_data_i,
   output logic      [WIDTH:0]   value_o
);

   typedef struct packed {
      logic             sticky;
      logic [WIDTH-1:0] count;
   } state_type;

   state_type state_q;
   state_type state_d;

   // The sticky bit must fit in a 32-bit register word above the count.
   if (WIDTH < 2 || WIDTH > 31) begin : g_bad_width
      $error("wrap_counter: WIDTH must be 2..31");
   end

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------

   // The parent only raises write_i while counting is stopped, so an
   // increment and a write never meet in the same cycle.
   always_comb begin
      state_d = state_q;
      if (write_i) begin
         state_d = state_type'(write_data_i);
      end else if (count_i) begin
         state_d.count = state_q.count + {{(WIDTH-1){1'b0}}, 1'b1};
         if (&state_q.count) begin
            state_d.sticky = 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign value_o = state_q;

endmodule

//--- hdl/core_performance_counters.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Counters only watch pipeline activity and never stall or alter execution.
// - Control bit 1 enables all five counters together; 0 stops them all.
// - Control bit 0 selects Normal mode (0) or Task mode (1) for every counter.
// - Normal mode counts each trigger from enable until disable.
// - Task mode additionally needs the debug start action to be active.
// - Counting mode means enable set and the selected mode active.
// - Counter writes during counting mode are ignored; value unchanged.
// - Counters read any time; writes accepted while counting is off.
// - Each counter is 31 bits and wraps to zero, never stopping.
// - Bit 31 sets when the low bits wrap and holds until software writes.
// - Counting starts the cycle enabled, with no pipeline stage alignment.
// - Three 3-bit fields at 4:2, 7:5, 10:8 select the event sources.
// - Control register resets to zero: counting off, Normal mode.
// - Cycle counts clocks, instruction counts retires, events are cache statistics.
module core_performance_counters #(
   parameter int SOURCES = perf_counter_pkg::event_source_count
) (
   input  wire logic               sys_clk_i,
   input  wire logic               reset_i,
   input  wire logic               reg_write_i,
   input  wire logic               reg_read_i,
   input  wire logic [15:0]        reg_addr_i,
   input  wire logic [31:0]        reg_write_data_i,
   output logic      [31:0]        reg_read_data_o,
   output logic                    reg_hit_o,
   input  wire logic               instruction_retired_i,
   input  wire logic               task_window_active_i,
   input  wire logic [SOURCES-1:0] event_sources_one_i,
   input  wire logic [SOURCES-1:0] event_sources_two_i,
   input  wire logic [SOURCES-1:0] event_sources_three_i,
   output logic                    counting_mode_o
);

   localparam int N = perf_counter_pkg::counter_total;
   localparam int W = perf_counter_pkg::count_width;

   // The three-bit select fields cannot address more than eight sources.
   if (SOURCES < 1 || SOURCES > 8) begin : g_bad_sources
      $error("core_performance_counters: SOURCES must be 1..8");
   end

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------

   typedef struct packed {
      logic [2:0] event_select_three;
      logic [2:0] event_select_two;
      logic [2:0] event_select_one;
      logic       count_enable;
      logic       counting_mode_select;
   } control_type;

   typedef struct packed {
      control_type counter_control;
      logic [31:0] read_data;
      logic        read_hit;
   } state_type;

   state_type state_q;
   state_type state_d;

   // -----------------------------------------------------------------
   // Counting mode
   // -----------------------------------------------------------------

   logic mode_active;
   logic counting;

   // Task mode gates on the debug start action; Normal mode is always active.
   // The debug signal comes from core logic on this same clock, so it is
   // used directly and counting starts in the cycle it is seen.
   assign mode_active = state_q.counter_control.counting_mode_select
                        ? task_window_active_i : 1'b1;
   assign counting    = state_q.counter_control.count_enable & mode_active;
   assign counting_mode_o = counting;

   // -----------------------------------------------------------------
   // Event selection
   // -----------------------------------------------------------------

   logic [N-1:0] trigger;
   logic [2:0]   selector [3];

   assign selector[0] = state_q.counter_control.event_select_one;
   assign selector[1] = state_q.counter_control.event_select_two;
   assign selector[2] = state_q.counter_control.event_select_three;

   // Cycle counter sees every clock, instruction counter every retire.
   assign trigger[0] = 1'b1;
   assign trigger[1] = instruction_retired_i;

   logic [SOURCES-1:0] event_sources [3];

   // Gather the three source vectors so one loop can serve every selector.
   assign event_sources[0] = event_sources_one_i;
   assign event_sources[1] = event_sources_two_i;
   assign event_sources[2] = event_sources_three_i;

   // One selector per event counter; they differ only in their inputs.
   for (genvar j = 0; j < 3; j++) begin : g_select
      event_select_mux #(
         .SOURCES (SOURCES)
      ) u_select (
         .events_i (event_sources[j]),
         .select_i (selector[j]),
         .event_o  (trigger[j + 2])
      );
   end

   // -----------------------------------------------------------------
   // Counters
   // -----------------------------------------------------------------

   logic [15:0] counter_offset [N];
   logic [31:0] counter_value  [N];
   logic [N-1:0] counter_write;

   assign counter_offset[0] = perf_counter_pkg::clock_cycle_counter_offset;
   assign counter_offset[1] = perf_counter_pkg::retired_instruction_counter_offset;
   assign counter_offset[2] = perf_counter_pkg::event_counter_one_offset;
   assign counter_offset[3] = perf_counter_pkg::event_counter_two_offset;
   assign counter_offset[4] = perf_counter_pkg::event_counter_three_offset;

   // Counters are pure observers: no output here feeds back into the
   // pipeline, so measurement cannot perturb execution.
   for (genvar i = 0; i < N; i++) begin : g_counter
      // A write is dropped while counting; writes never raise a hit, only reads do.
      assign counter_write[i] = reg_write_i && !counting
                                && (reg_addr_i == counter_offset[i]);

      wrap_counter #(
         .WIDTH (W)
      ) u_counter (
         .sys_clk_i    (sys_clk_i),
         .reset_i      (reset_i),
         .count_i      (counting & trigger[i]),
         .write_i      (counter_write[i]),
         .write_data_i (reg_write_data_i),
         .value_o      (counter_value[i])
      );
   end

   // -----------------------------------------------------------------
   // Register access
   // -----------------------------------------------------------------

   // Reads return a registered copy one cycle after the strobe.
   always_comb begin
      state_d           = state_q;
      state_d.read_hit  = 1'b0;
      state_d.read_data = 32'h0000_0000;
      if (reg_write_i && reg_addr_i == perf_counter_pkg::counter_control_offset) begin
         // Only the low eleven bits are stored; the rest are dropped.
         state_d.counter_control =
            control_type'(reg_write_data_i[perf_counter_pkg::control_width-1:0]);
      end
      if (reg_read_i) begin
         if (reg_addr_i == perf_counter_pkg::counter_control_offset) begin
            state_d.read_hit  = 1'b1;
            state_d.read_data = {21'h000000, state_q.counter_control};
         end
         for (int k = 0; k < N; k++) begin
            if (reg_addr_i == counter_offset[k]) begin
               state_d.read_hit  = 1'b1;
               state_d.read_data = counter_value[k];
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_q.counter_control <= control_type'(perf_counter_pkg::control_reset_value);
         state_q.read_data       <= 32'h0000_0000;
         state_q.read_hit        <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   assign reg_read_data_o = state_q.read_data;
   assign reg_hit_o       = state_q.read_hit;

endmodule

//--- verification/core_performance_counters_assertions.sv
`timescale 1ns/1ps
module core_performance_counters_checker (
   input wire logic        sys_clk_i,
   input wire logic        reset_i,
   input wire logic        reg_write_i,
   input wire logic        reg_read_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [31:0] reg_write_data_i,
   input wire logic [31:0] reg_read_data_o,
   input wire logic        reg_hit_o,
   input wire logic        task_window_active_i,
   input wire logic        counting_mode_o
);
   // -------------------------------------------------------------
   // Port-level checks
   // -------------------------------------------------------------
   // Shadow of the control word, so mode and read-back are judged at the ports alone.
   logic [10:0] ctrl_q;
   wire map_a  = reg_addr_i >= 16'hfc00 && reg_addr_i <= 16'hfc14 && reg_addr_i[1:0] == 2'b00;
   wire rd_cyc = reg_read_i && reg_addr_i == 16'hfc04;
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) ctrl_q <= 11'h000;
      else if (reg_write_i && reg_addr_i == 16'hfc00) ctrl_q <= reg_write_data_i[10:0];
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   a_mode_gate: assert property (
      counting_mode_o == (ctrl_q[1] && (!ctrl_q[0] || task_window_active_i)))
      else $error("counting mode wrong");
   a_reset_state: assert property (
      $fell(reset_i) |-> !counting_mode_o && !reg_hit_o && reg_read_data_o == 32'h0)
      else $error("state after reset wrong");
   a_cycle_step: assert property (
      (rd_cyc && counting_mode_o) ##1 rd_cyc
      |=> reg_read_data_o[30:0] == $past(reg_read_data_o[30:0]) + 31'd1)
      else $error("cycle counter did not step");
   a_cycle_hold: assert property (
      (rd_cyc && !counting_mode_o && !reg_write_i) ##1 rd_cyc
      |=> $stable(reg_read_data_o)) else $error("stopped counter moved");
   a_wrap_sets: assert property (
      (rd_cyc && counting_mode_o) ##1 (rd_cyc && reg_read_data_o[30:0] == 31'h7fffffff)
      |=> reg_read_data_o == 32'h8000_0000) else $error("wrap or sticky wrong");
   a_sticky_keep: assert property (
      (rd_cyc && !reg_write_i) ##1 rd_cyc
      |=> reg_read_data_o[31] || !$past(reg_read_data_o[31])) else $error("sticky lost");
   a_mapped_hit: assert property (
      reg_read_i && map_a |=> reg_hit_o) else $error("mapped read not acknowledged");
   a_unmapped_zero: assert property (
      reg_read_i && !map_a |=> !reg_hit_o && reg_read_data_o == 32'h0)
      else $error("unmapped read answered");
   a_idle_quiet: assert property (
      !reg_read_i |=> !reg_hit_o && reg_read_data_o == 32'h0) else $error("idle port busy");
   a_control_read: assert property (
      reg_read_i && reg_addr_i == 16'hfc00 |=> reg_read_data_o == {21'h0, $past(ctrl_q)})
      else $error("control read-back wrong");
   c_step: cover property ((rd_cyc && counting_mode_o) ##1 rd_cyc);
   c_task: cover property (counting_mode_o && ctrl_q[0]);
   c_drop: cover property (reg_write_i && counting_mode_o && reg_addr_i == 16'hfc04);
endmodule
bind core_performance_counters core_performance_counters_checker chk (
   .sys_clk_i, .reset_i, .reg_write_i, .reg_read_i, .reg_addr_i, .reg_write_data_i,
   .reg_read_data_o, .reg_hit_o, .task_window_active_i, .counting_mode_o);

//--- verification/pipeline_activity_model.sv
`timescale 1ns/1ps
module pipeline_activity_model (
   input  wire logic       sys_clk_i,
   output logic            retired_o,
   output logic            task_window_o,
   output logic [7:0]      events_one_o,
   output logic [7:0]      events_two_o,
   output logic [7:0]      events_three_o
);
   integer      seed = 32'h659a0600;
   logic [31:0] r;
   initial {retired_o, task_window_o, events_one_o, events_two_o, events_three_o} = '0;
   // Retires and cache events are redrawn every cycle; the debug window flips seldom,
   // so task-mode spans last several cycles as a real start action would.
   always @(posedge sys_clk_i) begin
      r = $random(seed);
      retired_o      <= r[0];
      events_one_o   <= r[8:1];
      events_two_o   <= r[16:9];
      events_three_o <= r[24:17];
      if (r[31:29] == 3'b000) task_window_o <= !task_window_o;
   end
endmodule

//--- verification/core_performance_counters_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module core_performance_counters_tb;
   logic        sys_clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        reg_write_i = 1'b0;
   logic        reg_read_i = 1'b0;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [31:0] reg_write_data_i = 32'h0, reg_read_data_o, pend_data = 32'h0, nxt;
   logic        reg_hit_o, counting_mode_o, retired, task_win, pend_hit = 1'b0, cm;
   logic [7:0]  ev1, ev2, ev3;
   logic [10:0] ctrl_m;
   logic [31:0] cnt_m [5];
   logic [4:0]  trig;
   integer      err_total = 0, tests_run = 0, seed = 32'h659a0600, r;
   core_performance_counters dut (.sys_clk_i, .reset_i, .reg_write_i, .reg_read_i,
      .reg_addr_i, .reg_write_data_i, .reg_read_data_o, .reg_hit_o,
      .instruction_retired_i(retired), .task_window_active_i(task_win),
      .event_sources_one_i(ev1), .event_sources_two_i(ev2), .event_sources_three_i(ev3),
      .counting_mode_o);
   pipeline_activity_model far (.sys_clk_i, .retired_o(retired), .task_window_o(task_win),
      .events_one_o(ev1), .events_two_o(ev2), .events_three_o(ev3));
   initial forever #5 sys_clk_i = !sys_clk_i;
   // -------------------------------------------------------------
   // Reference model
   // -------------------------------------------------------------
   function automatic logic [31:0] read_value(logic [15:0] a);
      if (a == 16'hfc00) return {21'h0, ctrl_m};
      if (a >= 16'hfc04 && a <= 16'hfc14 && a[1:0] == 2'b00) return cnt_m[(a - 16'hfc04) >> 2];
      return 32'h0;
   endfunction
   // Counting gate and the five triggers, cycle counter always firing.
   assign cm   = ctrl_m[1] && (!ctrl_m[0] || task_win);
   assign trig = {ev3[ctrl_m[10:8]], ev2[ctrl_m[7:5]], ev1[ctrl_m[4:2]], retired, 1'b1};
   // Model steps on the same edges as the block, so reads can be predicted exactly.
   always @(posedge sys_clk_i) begin
      pend_data <= (reg_read_i && !reset_i) ? read_value(reg_addr_i) : 32'h0;
      pend_hit  <= reg_read_i && !reset_i && reg_addr_i >= 16'hfc00 && reg_addr_i <= 16'hfc14
                   && reg_addr_i[1:0] == 2'b00;
      if (reset_i) ctrl_m <= 11'h000;
      else if (reg_write_i && reg_addr_i == 16'hfc00) ctrl_m <= reg_write_data_i[10:0];
      for (int i = 0; i < 5; i++) begin
         nxt = cnt_m[i];
         if (cm && trig[i]) nxt = {nxt[31] | (&nxt[30:0]), nxt[30:0] + 31'd1};
         if (reg_write_i && !cm && reg_addr_i == 16'hfc04 + 16'(4 * i)) nxt = reg_write_data_i;
         cnt_m[i] <= reset_i ? 32'h0 : nxt;
      end
   end
   // The read port is compared every cycle outside reset, idle ones too.
   always @(negedge sys_clk_i) begin
      if (!reset_i) begin
         `CHK("read data", pend_data, reg_read_data_o)
         `CHK("read hit", pend_hit, reg_hit_o)
         `CHK("counting mode", cm, counting_mode_o)
      end
   end
   // One bus cycle; strobes stay up into the next call, so calls run back to back.
   task automatic op(logic w, logic rd, logic [15:0] a, logic [31:0] d);
      reg_write_i      <= w;
      reg_read_i       <= rd;
      reg_addr_i       <= a;
      reg_write_data_i <= d;
      @(posedge sys_clk_i);
   endtask
   task automatic test_done;
      if (err_total == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   initial begin
      repeat (16) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      op(1'b0, 1'b1, 16'hfc00, 32'h0);
      // Park the cycle counter near its limit and read straight through the wrap.
      op(1'b1, 1'b0, 16'hfc04, 32'h7fff_fffa);
      op(1'b1, 1'b0, 16'hfc00, 32'h0000_0002);
      repeat (12) op(1'b0, 1'b1, 16'hfc04, 32'h0);
      op(1'b1, 1'b1, 16'hfc04, 32'h0);
      op(1'b1, 1'b0, 16'hfc00, 32'hffff_f800);
      op(1'b1, 1'b1, 16'hfc04, 32'h0);
      op(1'b0, 1'b1, 16'hfc04, 32'h0);
      op(1'b0, 1'b1, 16'hfc18, 32'h0);
      // Random traffic over every register and two unmapped words.
      repeat (3000) begin
         r = $random(seed);
         op(r[0], r[1], 16'hfc00 + 16'({r[4:2], 2'b00}), $random(seed));
      end
      reset_i <= 1'b1;
      repeat (3) op(1'b0, 1'b0, 16'h0, 32'h0);
      reset_i <= 1'b0;
      op(1'b0, 1'b1, 16'hfc00, 32'h0);
      op(1'b0, 1'b0, 16'h0, 32'h0);
      op(1'b0, 1'b0, 16'h0, 32'h0);
      test_done();
   end
   // A hang is cut short well after the scenarios should have finished.
   initial begin
      repeat (8000) @(posedge sys_clk_i);
      err_total++;
      test_done();
   end
endmodule
